// ===== inc/xbus_defs.svh
`ifndef XBUS_DEFS_SVH
`define XBUS_DEFS_SVH
// ==========================================================
// Address widths
`define XB_MEM_AW        24
`define XB_IO_AW         16
// ==========================================================
// Clock chip port numbers
`define XB_CLK_ADDR_PORT 16'h0070
`define XB_CLK_DATA_PORT 16'h0071
`define XB_CLK_PORT_MASK 16'hfffe
// ==========================================================
// Default decode windows, overridable by parameter
`define XB_ROM_BASE      24'h0f0000
`define XB_ROM_MASK      24'hff0000
`define XB_KBD_BASE      16'h0060
`define XB_KBD_MASK      16'hfffb
// ==========================================================
// Shared pin count and inactive pin levels
`define XB_SHARED_PINS   4
`define XB_PINS_IDLE     4'hf
`define XB_PIN_IDLE      1'b1
`endif

// ===== inc/xbus_pkg.sv
`include "xbus_defs.svh"
package xbus_pkg;
   // ==========================================================
   // One ISA command cycle, held for the whole cycle
   typedef struct packed {
      logic                      active;   // Command strobe phase
      logic                      io;       // I/O cycle, else memory
      logic                      write;    // Write, else read
      logic [`XB_MEM_AW-1:0]     addr;     // Low 16 bits for I/O
   } isa_cmd_s;

   // ==========================================================
   // Owner of the shared transceiver
   typedef enum logic [1:0] {
      ST_ISA,
      ST_TO_IDE,
      ST_IDE,
      ST_TO_ISA
   } owner_e;
endpackage

// ===== rtl/xbus_select_decoder.sv
`timescale 1ns/1ps
`include "xbus_defs.svh"
// Contract
// - Address strobe only on I/O write 70h
// - Shared select on memory ROM decode
// - Shared select on I/O clock decode
// - Keyboard select on I/O keyboard decode
// - Read/write strobe on I/O write 71h
// - Data strobe on I/O read 71h
// - Shared pins carry IDE data while IDE owns
// - Drive transceiver enable: ISA or IDE
module xbus_select_decoder #(
   parameter logic [`XB_MEM_AW-1:0] ROM_BASE = `XB_ROM_BASE,
   parameter logic [`XB_MEM_AW-1:0] ROM_MASK = `XB_ROM_MASK,
   parameter logic [`XB_IO_AW-1:0]  KBD_BASE = `XB_KBD_BASE,
   parameter logic [`XB_IO_AW-1:0]  KBD_MASK = `XB_KBD_MASK
) (
   input  wire logic                        clk_i,
   input  wire logic                        arst_n_i,
   input  wire xbus_pkg::isa_cmd_s          isa_cmd_i,
   input  wire logic                        ide_req_i,
   input  wire logic [`XB_SHARED_PINS-1:0]  ide_dd_i,
   output logic                             isa_ready_o,
   output logic                             ide_grant_o,
   output logic                             bus_xcvr_oe_n_o,
   output logic                             clock_addr_strobe_n_o,
   output logic                             rom_clock_select_n_o,
   output logic                             keyboard_select_n_o,
   output logic                             clock_rw_strobe_n_o,
   output logic                             clock_data_strobe_n_o
);

   // ==========================================================
   // Elaboration checks
   // A base with bits outside its mask could never match
   if ((ROM_BASE & ~ROM_MASK) != '0) begin : g_bad_rom
      $error("ROM base has bits outside its mask");
   end
   if ((KBD_BASE & ~KBD_MASK) != '0) begin : g_bad_kbd
      $error("Keyboard base has bits outside its mask");
   end

   // ==========================================================
   // Owner state machine
   xbus_pkg::owner_e state_q;   // Current transceiver owner
   xbus_pkg::owner_e state_d;   // Next owner

   // One idle cycle each way so the transceiver never fights
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         xbus_pkg::ST_ISA: begin
            // A running ISA cycle keeps the bus
            if (ide_req_i && !isa_cmd_i.active) begin
               state_d = xbus_pkg::ST_TO_IDE;
            end
         end
         xbus_pkg::ST_TO_IDE: begin
            state_d = xbus_pkg::ST_IDE;
         end
         xbus_pkg::ST_IDE: begin
            if (!ide_req_i) begin
               state_d = xbus_pkg::ST_TO_ISA;
            end
         end
         xbus_pkg::ST_TO_ISA: begin
            state_d = xbus_pkg::ST_ISA;
         end
      endcase
   end

   // Owner register
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= xbus_pkg::ST_ISA;
      end else begin
         state_q <= state_d;
      end
   end

   // ==========================================================
   // Address decode
   logic                 cyc_ok;     // Command seen while ISA owns
   logic [`XB_IO_AW-1:0] io_addr;    // I/O port number
   logic                 hit_rom;    // Memory cycle in ROM window
   logic                 hit_clk;    // I/O cycle to clock ports
   logic                 hit_kbd;    // I/O cycle to keyboard
   logic                 hit_cas;    // I/O write to address port
   logic                 hit_rw;     // I/O write to data port
   logic                 hit_ds;     // I/O read of data port

   assign io_addr = isa_cmd_i.addr[`XB_IO_AW-1:0];
   // Commands outside ISA ownership are ignored
   assign cyc_ok  = isa_cmd_i.active && (state_q == xbus_pkg::ST_ISA);

   // Decode qualifies address with command and I/O or memory class; only the three strobes also with direction
   always_comb begin
      hit_rom = cyc_ok && !isa_cmd_i.io &&
                ((isa_cmd_i.addr & ROM_MASK) == ROM_BASE);
      hit_clk = cyc_ok && isa_cmd_i.io &&
                ((io_addr & `XB_CLK_PORT_MASK) ==
                 `XB_CLK_ADDR_PORT);
      hit_kbd = cyc_ok && isa_cmd_i.io &&
                ((io_addr & KBD_MASK) == KBD_BASE);
      hit_cas = cyc_ok && isa_cmd_i.io && isa_cmd_i.write &&
                (io_addr == `XB_CLK_ADDR_PORT);
      hit_rw  = cyc_ok && isa_cmd_i.io && isa_cmd_i.write &&
                (io_addr == `XB_CLK_DATA_PORT);
      hit_ds  = cyc_ok && isa_cmd_i.io && !isa_cmd_i.write &&
                (io_addr == `XB_CLK_DATA_PORT);
   end

   // ==========================================================
   // Pin registers
   // Address strobe has its own pin, never shared
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clock_addr_strobe_n_o <= `XB_PIN_IDLE;
      end else begin
         clock_addr_strobe_n_o <= !hit_cas;
      end
   end

   // Shared pins: ISA selects, or IDE data when IDE owns
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         {rom_clock_select_n_o, keyboard_select_n_o,
          clock_rw_strobe_n_o, clock_data_strobe_n_o}
            <= `XB_PINS_IDLE;
      end else if (state_d == xbus_pkg::ST_IDE) begin
         {rom_clock_select_n_o, keyboard_select_n_o,
          clock_rw_strobe_n_o, clock_data_strobe_n_o}
            <= ide_dd_i;
      end else begin
         // Held low for as long as the command stays active
         rom_clock_select_n_o  <= !(hit_rom || hit_clk);
         keyboard_select_n_o   <= !hit_kbd;
         clock_rw_strobe_n_o   <= !hit_rw;
         clock_data_strobe_n_o <= !hit_ds;
      end
   end

   // Transceiver enable and ownership flags
   // High enable also gates the selects off at the board
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bus_xcvr_oe_n_o <= 1'b0;
         ide_grant_o     <= 1'b0;
         isa_ready_o     <= 1'b1;
      end else begin
         bus_xcvr_oe_n_o <= (state_d == xbus_pkg::ST_IDE);
         ide_grant_o     <= (state_d == xbus_pkg::ST_IDE);
         isa_ready_o     <= (state_d == xbus_pkg::ST_ISA);
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   logic [`XB_SHARED_PINS-1:0] shared_pins;  // Shared pin view
   assign shared_pins = {rom_clock_select_n_o, keyboard_select_n_o,
                         clock_rw_strobe_n_o, clock_data_strobe_n_o};

   chk_addr_strobe_set: assert property (
      (cyc_ok && isa_cmd_i.io && isa_cmd_i.write &&
       io_addr == `XB_CLK_ADDR_PORT) |=> !clock_addr_strobe_n_o)
      else $error("address strobe missing on write to 70h");
   // Refused commands count as foreign cycles here as well
   chk_addr_strobe_idle: assert property (
      !(cyc_ok && isa_cmd_i.io && isa_cmd_i.write &&
        io_addr == `XB_CLK_ADDR_PORT) |=> clock_addr_strobe_n_o)
      else $error("address strobe on a foreign cycle");
   chk_rom_select_set: assert property (
      (cyc_ok && !isa_cmd_i.io &&
       (isa_cmd_i.addr & ROM_MASK) == ROM_BASE)
      |=> !rom_clock_select_n_o)
      else $error("shared select missing on ROM cycle");
   chk_clock_select_set: assert property (
      (cyc_ok && isa_cmd_i.io &&
       (io_addr & `XB_CLK_PORT_MASK) == `XB_CLK_ADDR_PORT)
      |=> !rom_clock_select_n_o)
      else $error("shared select missing on clock cycle");
   chk_kbd_select_set: assert property (
      (cyc_ok && isa_cmd_i.io && (io_addr & KBD_MASK) == KBD_BASE)
      |=> !keyboard_select_n_o && !bus_xcvr_oe_n_o)
      else $error("keyboard select missing");
   chk_rw_strobe_set: assert property (
      (cyc_ok && isa_cmd_i.io && isa_cmd_i.write &&
       io_addr == `XB_CLK_DATA_PORT) |=> !clock_rw_strobe_n_o)
      else $error("read/write strobe missing on write to 71h");
   chk_data_strobe_set: assert property (
      (cyc_ok && isa_cmd_i.io && !isa_cmd_i.write &&
       io_addr == `XB_CLK_DATA_PORT) |=> !clock_data_strobe_n_o)
      else $error("data strobe missing on read of 71h");
   chk_ide_pins_pass: assert property (
      bus_xcvr_oe_n_o |-> shared_pins == $past(ide_dd_i))
      else $error("shared pins not carrying IDE data");
   chk_grant_oe_tie: assert property (
      ide_grant_o == bus_xcvr_oe_n_o && !(ide_grant_o && isa_ready_o))
      else $error("transceiver enable disagrees with owner");
   chk_turn_gap: assert property (
      $rose(bus_xcvr_oe_n_o) |-> $past(shared_pins) == `XB_PINS_IDLE)
      else $error("IDE took pins without idle cycle");
   // Hand-back keeps the pins idle and ISA waits one more cycle
   chk_hand_back: assert property (
      $fell(bus_xcvr_oe_n_o) |->
      ((shared_pins == `XB_PINS_IDLE) && !isa_ready_o) ##1 isa_ready_o)
      else $error("ISA resumed without idle cycle");
   chk_cycle_hold: assert property (
      (cyc_ok && $past(cyc_ok) && $stable(isa_cmd_i))
      |=> $stable(shared_pins))
      else $error("select changed within a steady cycle");

   cov_clock_write: cover property (!clock_addr_strobe_n_o ##[1:20]
                                    !clock_rw_strobe_n_o);
   cov_clock_read: cover property (!clock_data_strobe_n_o);
   cov_ide_handover: cover property ($rose(ide_grant_o) ##[1:50]
                                     $fell(ide_grant_o));
   cov_cmd_refused: cover property (isa_cmd_i.active && !isa_ready_o);
   // Keyboard access seen at the pin
   cov_kbd_access: cover property (!keyboard_select_n_o);
endmodule

// ===== tb/xbus_board_model.sv
`timescale 1ns/1ps
// ==========================================================
// Board gating between the decoder and the peripheral chips
module xbus_board_model (
   input  wire logic       xcvr_oe_n_i, // High while IDE owns pins
   input  wire logic [3:0] pins_i,      // Select, kbd, rw, ds
   input  wire logic       mem_cmd_i,   // Memory command active
   input  wire logic       io_cmd_i,    // I/O command active
   output logic            rom_en_n_o,  // ROM chip enable
   output logic            clock_en_n_o, // Clock chip enable
   output logic [2:0]      per_n_o      // Kbd, rw, ds at chips
);
   logic [3:0] gated; // Buffer output, pulled up while disabled
   // Buffer off in IDE phase, so weak pull-ups hold chips idle
   assign gated = pins_i | {4{xcvr_oe_n_i}};
   // Shared select only counts with its own command class
   assign rom_en_n_o   = gated[3] | ~mem_cmd_i;
   assign clock_en_n_o = gated[3] | ~io_cmd_i;
   assign per_n_o      = gated[2:0];
endmodule

// ===== tb/xbus_peripheral_select_decoder_tb.sv
`timescale 1ns/1ps
module xbus_peripheral_select_decoder_tb;
   // ==========================================================
   // Stimulus and observation
   logic               clk_i = 1'b0;    // 50 MHz clock
   logic               arst_n_i = 1'b0; // Async reset
   xbus_pkg::isa_cmd_s cmd = '0;        // Command under test
   logic               ide_req = 1'b0;  // IDE wants the pins
   logic [3:0]         ide_dd = 4'h0;   // IDE data for pins
   logic               rdy, gnt, oe_n;  // Ownership outputs
   logic [4:0]         sel_n;           // cas, rcs, kbd, rw, ds
   logic               rom_en_n, clk_en_n; // Enables at chips
   logic [2:0]         per_n;           // Strobes at chips
   int                 error_cnt = 0;   // Mismatches
   int                 checks_done = 0; // Comparisons
   // Entries: io, write, expected selects, address
   logic [30:0]        tbl [10] = '{
      {2'b11, 5'h07, 24'h70}, {2'b10, 5'h16, 24'h71},
      {2'b11, 5'h15, 24'h71}, {2'b10, 5'h17, 24'h70},
      {2'b00, 5'h17, 24'h0f1234}, {2'b01, 5'h1f, 24'h0e0070},
      {2'b10, 5'h1b, 24'h60}, {2'b11, 5'h1b, 24'h64},
      {2'b10, 5'h1f, 24'h72}, {2'b11, 5'h1f, 24'h0170}};
   always #10 clk_i = ~clk_i; // 20 ns period
   xbus_select_decoder dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .isa_cmd_i(cmd), .ide_req_i(ide_req), .ide_dd_i(ide_dd),
      .isa_ready_o(rdy), .ide_grant_o(gnt), .bus_xcvr_oe_n_o(oe_n),
      .clock_addr_strobe_n_o(sel_n[4]), .rom_clock_select_n_o(sel_n[3]),
      .keyboard_select_n_o(sel_n[2]), .clock_rw_strobe_n_o(sel_n[1]),
      .clock_data_strobe_n_o(sel_n[0]));
   xbus_board_model board (.xcvr_oe_n_i(oe_n), .pins_i(sel_n[3:0]),
      .mem_cmd_i(cmd.active & ~cmd.io), .io_cmd_i(cmd.active & cmd.io),
      .rom_en_n_o(rom_en_n), .clock_en_n_o(clk_en_n), .per_n_o(per_n));
   // ==========================================================
   // Shared compare and closing
   task automatic check(input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Five cycles of reset, released on a falling edge
   task automatic reset_dut();
      arst_n_i = 1'b0;
      repeat (5) @(negedge clk_i);
      check(8'h9f, {rdy, gnt, oe_n, sel_n});
      arst_n_i = 1'b1;
   endtask
   // Back to back decodes, command changes every cycle
   task automatic decode_test();
      for (int i = 0; i < 10; i++) begin
         cmd = {1'b1, tbl[i][30:29], tbl[i][23:0]};
         @(negedge clk_i);
         check({3'h0, tbl[i][28:24]},
               {3'h0, sel_n});
         check({6'h0, tbl[i][27] | tbl[i][30], tbl[i][27] | ~tbl[i][30]},
               {6'h0, rom_en_n, clk_en_n});
      end
      cmd.active = 1'b0;
      @(negedge clk_i);
      check(8'h1f, {3'h0, sel_n});
      $display("test decode done");
   endtask
   // Hand pins to IDE, refused command, hand back
   task automatic own_test();
      ide_req = 1'b1;
      ide_dd  = 4'ha;
      @(negedge clk_i);
      check(8'h1f, {rdy, gnt, oe_n, sel_n});
      cmd = {1'b1, 1'b1, 1'b1, 24'h70};
      @(negedge clk_i);
      check(8'h7a, {rdy, gnt, oe_n, sel_n});
      check(8'h1f, {3'h0, rom_en_n, clk_en_n, per_n});
      ide_dd = 4'h5;
      @(negedge clk_i);
      check(8'h75, {rdy, gnt, oe_n, sel_n});
      cmd.active = 1'b0;
      ide_req    = 1'b0;
      @(negedge clk_i);
      check(8'h1f, {rdy, gnt, oe_n, sel_n});
      @(negedge clk_i);
      check(8'h9f, {rdy, gnt, oe_n, sel_n});
      $display("test ownership done");
   endtask
   // IDE request waits while a command is active
   task automatic wait_test();
      cmd     = {1'b1, 1'b1, 1'b0, 24'h71};
      ide_req = 1'b1;
      repeat (3) begin
         @(negedge clk_i);
         check(8'h96, {rdy, gnt, oe_n, sel_n});
      end
      cmd.active = 1'b0;
      ide_req    = 1'b0;
      @(negedge clk_i);
      check(8'h9f, {rdy, gnt, oe_n, sel_n});
      $display("test priority done");
   endtask
   // Reset in mid command clears selects at once
   task automatic rst_test();
      cmd = {1'b1, 1'b1, 1'b1, 24'h70};
      @(negedge clk_i);
      arst_n_i = 1'b0;
      #1;
      check(8'h9f, {rdy, gnt, oe_n, sel_n});
      cmd.active = 1'b0;
      reset_dut();
      $display("test reset done");
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      reset_dut();
      decode_test();
      own_test();
      wait_test();
      rst_test();
      decode_test();
      conclude();
   end
   // Run needs about 0.84 us; far longer means a hang
   initial begin
      #100000;
      error_cnt++;
      conclude();
   end
endmodule
